/* rtl/acu_pkg.sv */
// Operation
// [RULE1] Over-sampling clock output programmable to 40 MHz, sub-hertz resolution; the phase accumulator top bit reaches 20 MHz at most.
// [RULE2] Software programs the over-sampling clock to 256 or 384 times sample rate.
// [RULE3] After reset the receiver is timing slave; bit clock pin is an input.
// [RULE4] Slave bit clock is asynchronous to the main clock; synchronise it.
// [RULE5] Master drives bit clock as over-sampling clock over an integer divisor.
// [RULE6] Bit clock never exceeds 22 MHz, in either role.
// [RULE7] Serial data sampled on rising or falling bit-clock edge, software selected.
// [RULE8] Slave word select is an input sampled on the data sampling edge.
// [RULE9] Master drives word select, changing on the edge opposite the sampling edge.
// [RULE10] Block only receives data; it may be timing master or slave.
// [RULE11] Variable valid sample rate; no fixed bit-clock to sample ratio needed.
// [RULE12] Samples reach the main clock domain through a safe synchronising path.
package acu_pkg;
    // Register byte offsets
    localparam logic [3:0] ACU_CTRL_OFS = 4'h0;
    localparam logic [3:0] ACU_OSC_INC_OFS = 4'h4;
    localparam logic [3:0] ACU_DIVISOR_OFS = 4'h8;
    localparam logic [3:0] ACU_STATUS_OFS = 4'hc;
    // Control field positions (capture_serial_config_reg)
    localparam int ACU_CTRL_ENABLE_BIT = 0;
    localparam int ACU_CTRL_MASTER_BIT = 1;
    localparam int ACU_CTRL_EDGE_BIT = 2;
    // Status field positions
    localparam int ACU_STAT_OVERFLOW_BIT = 0;
    localparam int ACU_STAT_PENDING_BIT = 1;
    localparam int ACU_STAT_MASTER_BIT = 2;
    // Reset values
    localparam logic [2:0] ACU_CTRL_RESET = 3'h0;
    localparam logic [31:0] ACU_OSC_INC_RESET = 32'h0000_0000;
    localparam logic [15:0] ACU_DIVISOR_RESET = 16'h0001;
    // Timing figures
    localparam int ACU_MCLK_HZ = 40_000_000;
    localparam int ACU_OSC_MAX_HZ = 40_000_000;
    localparam int ACU_BCLK_MAX_HZ = 22_000_000;
    localparam int ACU_SYNC_STAGES = 2;
    // Link timing role
    typedef enum logic {ACU_ROLE_SLAVE, ACU_ROLE_MASTER} acu_role_t;
endpackage

/* rtl/acu_sample_buffer.sv */
// Two-entry buffer between capture logic and the sample consumer
module acu_sample_buffer #(
    parameter int WIDTH = 17
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    logic [WIDTH-1:0] entry_ff [2];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] count_ff;
    logic push;
    logic pop;

    // Honest full and empty flags
    assign in_ready_out = (count_ff != 2'h2);
    assign out_valid_out = (count_ff != 2'h0);
    assign out_data_out = entry_ff[rd_ptr_ff];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Entry storage, no reset needed on data
    always_ff @(posedge mclk_in)
    begin
        if (push)
        begin
            entry_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop)
            begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            if (push && !pop)
            begin
                count_ff <= count_ff + 2'h1;
            end
            else if (pop && !push)
            begin
                count_ff <= count_ff - 2'h1;
            end
        end
    end
endmodule // acu_sample_buffer

/* rtl/acu_capture.sv */
// Audio capture receiver with Avalon-MM registers and a sample stream out
//
// Our own choices: the register offsets and the Avalon-MM register port.
module acu_capture #(
    parameter int SAMPLE_BITS = 16,
    parameter int WORD_BITS = 16
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Serial link pins
    output logic capture_oversample_clock_out,
    input wire logic capture_bit_clock_in,
    output logic capture_bit_clock_out,
    output logic capture_bit_clock_oe_out,
    input wire logic capture_word_select_in,
    output logic capture_word_select_out,
    output logic capture_word_select_oe_out,
    input wire logic capture_serial_data_in,
    // Sample stream toward memory logic
    output logic sample_valid_out,
    input wire logic sample_ready_in,
    output logic [SAMPLE_BITS-1:0] sample_data_out,
    output logic sample_chan_out
);
    logic enable_ff;
    logic edge_rise_ff;
    acu_pkg::acu_role_t role_ff;
    logic [31:0] osc_inc_ff;
    logic [15:0] divisor_ff;
    logic overflow_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [31:0] phase_ff;
    logic osc_prev_ff;
    logic [15:0] half_cnt_ff;
    logic bclk_gen_ff;
    logic ws_gen_ff;
    logic [$clog2(WORD_BITS+1)-1:0] ws_cnt_ff;
    logic [acu_pkg::ACU_SYNC_STAGES-1:0] sck_sync_ff;
    logic [acu_pkg::ACU_SYNC_STAGES-1:0] ws_sync_ff;
    logic [acu_pkg::ACU_SYNC_STAGES-1:0] sd_sync_ff;
    logic sck_last_ff;
    logic [SAMPLE_BITS-1:0] shift_ff;
    logic ws_last_ff;
    logic osc_rise;
    logic osc_fall;
    logic half_done;
    logic gen_rise;
    logic gen_fall;
    logic slv_rise;
    logic slv_fall;
    logic sample_edge;
    logic change_edge;
    logic ws_now;
    logic sd_now;
    logic [SAMPLE_BITS-1:0] nxt_shift;
    logic word_done;
    logic buf_ready;
    logic bus_req;
    logic is_master;

    assign bus_req = avs_read_in || avs_write_in;
    assign is_master = (role_ff == acu_pkg::ACU_ROLE_MASTER);

    // One wait cycle per access; the answer comes at the second edge
    assign avs_waitrequest_out = bus_req && !ack_ff;
    assign avs_readdata_out = rdata_ff;

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ack_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= bus_req && !ack_ff;
        end
    end

    // Control register writes, honouring byte lanes
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            enable_ff <= acu_pkg::ACU_CTRL_RESET[acu_pkg::ACU_CTRL_ENABLE_BIT];
            role_ff <= acu_pkg::ACU_ROLE_SLAVE; // [RULE3]
            edge_rise_ff <= acu_pkg::ACU_CTRL_RESET[acu_pkg::ACU_CTRL_EDGE_BIT];
            divisor_ff <= acu_pkg::ACU_DIVISOR_RESET;
        end
        else if (avs_write_in && !ack_ff)
        begin
            if (avs_address_in == acu_pkg::ACU_CTRL_OFS && avs_byteenable_in[0])
            begin
                enable_ff <= avs_writedata_in[acu_pkg::ACU_CTRL_ENABLE_BIT];
                role_ff <= acu_pkg::acu_role_t'(avs_writedata_in[acu_pkg::ACU_CTRL_MASTER_BIT]);
                edge_rise_ff <= avs_writedata_in[acu_pkg::ACU_CTRL_EDGE_BIT]; // [RULE7]
            end
            else if (avs_address_in == acu_pkg::ACU_DIVISOR_OFS)
            begin
                if (avs_byteenable_in[0])
                begin
                    divisor_ff[7:0] <= avs_writedata_in[7:0]; // [RULE5]
                end
                if (avs_byteenable_in[1])
                begin
                    divisor_ff[15:8] <= avs_writedata_in[15:8];
                end
            end
        end
    end

    // Phase increment, one lane per byte enable
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_inc_lane
            always_ff @(posedge mclk_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                begin
                    osc_inc_ff[lane*8 +: 8] <= acu_pkg::ACU_OSC_INC_RESET[lane*8 +: 8];
                end
                else if (avs_write_in && !ack_ff && avs_byteenable_in[lane]
                         && avs_address_in == acu_pkg::ACU_OSC_INC_OFS)
                begin
                    osc_inc_ff[lane*8 +: 8] <= avs_writedata_in[lane*8 +: 8]; // [RULE1] [RULE2]
                end
            end
        end
    endgenerate

    // Read data captured on the first cycle of a read; unmapped reads give zero
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rdata_ff <= 32'h0000_0000;
        end
        else if (avs_read_in && !ack_ff)
        begin
            if (avs_address_in == acu_pkg::ACU_CTRL_OFS)
            begin
                rdata_ff <= {29'h0, edge_rise_ff, is_master, enable_ff};
            end
            else if (avs_address_in == acu_pkg::ACU_OSC_INC_OFS)
            begin
                rdata_ff <= osc_inc_ff;
            end
            else if (avs_address_in == acu_pkg::ACU_DIVISOR_OFS)
            begin
                rdata_ff <= {16'h0, divisor_ff};
            end
            else if (avs_address_in == acu_pkg::ACU_STATUS_OFS)
            begin
                rdata_ff <= {29'h0, is_master, sample_valid_out, overflow_ff};
            end
            else
            begin
                rdata_ff <= 32'h0000_0000;
            end
        end
    end

    // Overflow flag: a new overflow wins over a write-one clear in the same cycle
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            overflow_ff <= 1'b0;
        end
        else if (word_done && !buf_ready)
        begin
            overflow_ff <= 1'b1;
        end
        else if (avs_write_in && !ack_ff && avs_address_in == acu_pkg::ACU_STATUS_OFS
                 && avs_byteenable_in[0] && avs_writedata_in[acu_pkg::ACU_STAT_OVERFLOW_BIT])
        begin
            overflow_ff <= 1'b0;
        end
    end

    // Phase accumulator: 32 bits at 40 MHz steps below 0.01 Hz
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            phase_ff <= 32'h0000_0000;
            osc_prev_ff <= 1'b0;
        end
        else
        begin
            phase_ff <= phase_ff + osc_inc_ff; // [RULE1]
            osc_prev_ff <= phase_ff[31];
        end
    end

    // Top bit of the phase is the over-sampling clock; output is limited by the main clock rate
    assign capture_oversample_clock_out = phase_ff[31]; // [RULE1]
    assign osc_rise = phase_ff[31] && !osc_prev_ff;
    assign osc_fall = !phase_ff[31] && osc_prev_ff;

    // Bit clock generator: toggles every divisor half periods, so it is oversample / divisor
    assign half_done = (half_cnt_ff >= divisor_ff) || (divisor_ff == 16'h0);

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            half_cnt_ff <= 16'h1;
            bclk_gen_ff <= 1'b0;
        end
        else if (!is_master || !enable_ff)
        begin
            half_cnt_ff <= 16'h1;
            bclk_gen_ff <= 1'b0;
        end
        else if (osc_rise || osc_fall)
        begin
            if (half_done)
            begin
                half_cnt_ff <= 16'h1;
                bclk_gen_ff <= ~bclk_gen_ff; // [RULE5] [RULE6]
            end
            else
            begin
                half_cnt_ff <= half_cnt_ff + 16'h1;
            end
        end
    end

    assign gen_rise = is_master && enable_ff && (osc_rise || osc_fall) && half_done
                      && !bclk_gen_ff;
    assign gen_fall = is_master && enable_ff && (osc_rise || osc_fall) && half_done
                      && bclk_gen_ff;

    // Slave pins pass two flops before anyone looks at them
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sck_sync_ff <= '0;
            ws_sync_ff <= '0;
            sd_sync_ff <= '0;
            sck_last_ff <= 1'b0;
        end
        else
        begin
            sck_sync_ff <= {sck_sync_ff[0], capture_bit_clock_in}; // [RULE4]
            ws_sync_ff <= {ws_sync_ff[0], capture_word_select_in};
            sd_sync_ff <= {sd_sync_ff[0], capture_serial_data_in};
            sck_last_ff <= sck_sync_ff[1];
        end
    end

    // Slave edges need the bit clock below half the main clock to be seen
    assign slv_rise = sck_sync_ff[1] && !sck_last_ff; // [RULE4] [RULE6]
    assign slv_fall = !sck_sync_ff[1] && sck_last_ff;

    // Sampling edge and the opposite edge, per role and edge select
    always_comb
    begin
        if (!enable_ff)
        begin
            sample_edge = 1'b0;
            change_edge = 1'b0;
        end
        else if (is_master)
        begin
            sample_edge = edge_rise_ff ? gen_rise : gen_fall; // [RULE7]
            change_edge = edge_rise_ff ? gen_fall : gen_rise; // [RULE9]
        end
        else
        begin
            sample_edge = edge_rise_ff ? slv_rise : slv_fall; // [RULE7] [RULE8]
            change_edge = 1'b0;
        end
    end

    // Master word select counts whole channel slots
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ws_gen_ff <= 1'b0;
            ws_cnt_ff <= '0;
        end
        else if (!is_master || !enable_ff)
        begin
            ws_gen_ff <= 1'b0;
            ws_cnt_ff <= '0;
        end
        else if (change_edge)
        begin
            if (ws_cnt_ff == ($clog2(WORD_BITS+1))'(WORD_BITS - 1))
            begin
                ws_cnt_ff <= '0;
                ws_gen_ff <= ~ws_gen_ff; // [RULE9]
            end
            else
            begin
                ws_cnt_ff <= ws_cnt_ff + 1'b1;
            end
        end
    end

    // Pins: receive only, clock and word select driven solely as master
    assign capture_bit_clock_out = bclk_gen_ff; // [RULE5]
    assign capture_bit_clock_oe_out = is_master; // [RULE3]
    assign capture_word_select_out = ws_gen_ff;
    assign capture_word_select_oe_out = is_master; // [RULE9] [RULE10]

    // Word select as seen on the sampling edge
    assign ws_now = is_master ? ws_gen_ff : ws_sync_ff[1]; // [RULE8]
    assign sd_now = sd_sync_ff[1];
    assign nxt_shift = {shift_ff[SAMPLE_BITS-2:0], sd_now};
    // A word ends when word select moves, whatever the bit count between moves
    assign word_done = sample_edge && (ws_now != ws_last_ff); // [RULE11]

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            shift_ff <= '0;
            ws_last_ff <= 1'b0;
        end
        else if (sample_edge)
        begin
            shift_ff <= nxt_shift; // [RULE10]
            ws_last_ff <= ws_now;
        end
    end

    // Completed words enter the buffer; a full buffer drops the word and flags overflow
    acu_sample_buffer #(
        .WIDTH(SAMPLE_BITS + 1)
    ) u_buffer (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(word_done), // [RULE12]
        .in_ready_out(buf_ready),
        .in_data_in({ws_last_ff, nxt_shift}),
        .out_valid_out(sample_valid_out),
        .out_ready_in(sample_ready_in),
        .out_data_out({sample_chan_out, sample_data_out})
    );
endmodule // acu_capture

/* test/acu_capture_props.sv */
module acu_capture_props #(
    parameter int SAMPLE_BITS = 16
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic capture_bit_clock_out,
    input wire logic capture_bit_clock_oe_out,
    input wire logic capture_word_select_out,
    input wire logic capture_word_select_oe_out,
    input wire logic sample_valid_out,
    input wire logic sample_ready_in,
    input wire logic [SAMPLE_BITS-1:0] sample_data_out,
    input wire logic sample_chan_out
);
    logic mst_ff;
    logic edge_ff;
    logic ctrl_wr;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    // Mirror role and edge bits at the edge the design takes the write (first, waiting cycle)
    assign ctrl_wr = avs_write_in && avs_waitrequest_out && avs_byteenable_in[0]
        && avs_address_in == acu_pkg::ACU_CTRL_OFS;
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mst_ff <= 1'b0;
            edge_ff <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            mst_ff <= avs_writedata_in[acu_pkg::ACU_CTRL_MASTER_BIT];
            edge_ff <= avs_writedata_in[acu_pkg::ACU_CTRL_EDGE_BIT];
        end
    end
    slave_idle_a: assert property (!capture_word_select_oe_out
        |=> !capture_word_select_out && !capture_bit_clock_out)
        else $error("generated clock or word select runs in slave role");
    role_oe_a: assert property ($stable(mst_ff) [*3] |-> capture_bit_clock_oe_out == mst_ff)
        else $error("pin drive does not follow timing role");
    ws_edge_a: assert property (capture_word_select_oe_out && $past(capture_word_select_oe_out)
        && $changed(capture_word_select_out)
        |-> $changed(capture_bit_clock_out) && capture_bit_clock_out != edge_ff)
        else $error("word select moved off the non-sampling edge");
    valid_hold_a: assert property (sample_valid_out && !sample_ready_in |=> sample_valid_out)
        else $error("stalled sample withdrawn");
    data_hold_a: assert property (sample_valid_out && !sample_ready_in
        |=> $stable(sample_data_out) && $stable(sample_chan_out))
        else $error("stalled sample changed");
    wait_state_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out)
        else $error("bus answer later than one wait state");
    idle_wait_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("wait request without a request");
    rd_hold_a: assert property (!avs_read_in |=> $stable(avs_readdata_out))
        else $error("read data changed without a read");
    pop_c: cover property (sample_valid_out && sample_ready_in);
    stall_c: cover property ((sample_valid_out && !sample_ready_in) [*3]);
    master_c: cover property ($rose(capture_bit_clock_oe_out));
    ws_c: cover property (capture_word_select_oe_out && $changed(capture_word_select_out));
endmodule // acu_capture_props

bind acu_capture acu_capture_props #(.SAMPLE_BITS(SAMPLE_BITS)) u_props (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .capture_bit_clock_out(capture_bit_clock_out),
    .capture_bit_clock_oe_out(capture_bit_clock_oe_out),
    .capture_word_select_out(capture_word_select_out),
    .capture_word_select_oe_out(capture_word_select_oe_out),
    .sample_valid_out(sample_valid_out), .sample_ready_in(sample_ready_in),
    .sample_data_out(sample_data_out), .sample_chan_out(sample_chan_out)
);

/* test/acu_adc_model.sv */
module acu_adc_model #(
    parameter int HALF_NS = 150
) (
    input wire logic master_in,
    input wire logic rise_in,
    input wire logic bclk_dev_in,
    input wire logic ws_dev_in,
    input wire logic [15:0] left_in,
    input wire logic [15:0] right_in,
    output logic bclk_out,
    output logic ws_out,
    output logic sd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [16:0] q = 17'h0;
    logic ws_seen = 1'b0;
    initial
    begin
        bclk_out = 1'b0;
        ws_out = 1'b0;
        sd_out = 1'b0;
    end
    // Slave role: model owns the clock, ~3.3 MHz, still between frames
    task automatic send_frame(input logic [15:0] l, input logic [15:0] r);
        logic [32:0] bits;
        bits = {1'b0, l, r};
        #7;
        for (int k = 0; k < 33; k++)
        begin
            bclk_out = !rise_in;
            ws_out = (k >= 16 && k < 32); // Word select leads data by one bit
            sd_out = bits[32-k];
            #(HALF_NS);
            bclk_out = rise_in; // Sampling edge
            #(HALF_NS);
        end
        bclk_out = !rise_in;
        sd_out = !sd_out; // Released line must not keep a stale level
    endtask
    // Master role: data moves on the device's non-sampling edge, one bit behind word select
    always @(bclk_dev_in)
    begin
        #1;
        if (master_in && bclk_dev_in != rise_in)
        begin
            sd_out = q[16];
            q = q << 1;
            if (ws_dev_in != ws_seen)
                q = {(ws_dev_in ? right_in : left_in), 1'b0};
            ws_seen = ws_dev_in;
        end
    end
endmodule // acu_adc_model

/* test/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, rq;
    logic wait_r, osc, bclk_d, bclk_oe, ws_d, ws_oe, bclk_m, ws_m, sd, valid, chan;
    logic rdy = 1'b0;
    logic rdy_on = 1'b1;
    logic rise = 1'b1;
    logic [15:0] data, lw, rw;
    int error_cnt = 0;
    int compares = 0;
    int seed = 32'h1014;
    logic [16:0] got[$];
    logic [16:0] exp[$];
    wire bclk_pin = bclk_oe ? bclk_d : bclk_m;
    wire ws_pin = ws_oe ? ws_d : ws_m;
    acu_capture dut (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
        .capture_oversample_clock_out(osc), .capture_bit_clock_in(bclk_pin),
        .capture_bit_clock_out(bclk_d), .capture_bit_clock_oe_out(bclk_oe),
        .capture_word_select_in(ws_pin), .capture_word_select_out(ws_d),
        .capture_word_select_oe_out(ws_oe), .capture_serial_data_in(sd),
        .sample_valid_out(valid), .sample_ready_in(rdy), .sample_data_out(data),
        .sample_chan_out(chan)
    );
    acu_adc_model adc (
        .master_in(bclk_oe), .rise_in(rise), .bclk_dev_in(bclk_pin), .ws_dev_in(ws_pin),
        .left_in(lw), .right_in(rw), .bclk_out(bclk_m), .ws_out(ws_m), .sd_out(sd)
    );
    initial
    begin
        forever #12.5 mclk_in = !mclk_in;
    end
    // Consumer stalls at random; popped words are logged
    always @(posedge mclk_in)
    begin
        if (valid === 1'b1 && rdy)
            got.push_back({chan, data});
        rdy <= rdy_on & 1'($random(seed));
    end
    task automatic report_and_stop();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard, well past the expected ~9k cycles
    initial
    begin
        repeat (60000) @(posedge mclk_in);
        error_cnt++;
        report_and_stop();
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // One bus cycle, held until wait request is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge mclk_in);
        while (wait_r !== 1'b0)
            @(posedge mclk_in);
        rq = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rq, e);
    endtask
    function automatic logic [16:0] word_of(input logic c, input logic [15:0] v);
        return {c, v};
    endfunction
    task automatic frames(input int n);
        repeat (n)
        begin
            lw = 16'($random(seed));
            rw = 16'($random(seed));
            adc.send_frame(lw, rw);
            exp.push_back(word_of(1'b0, lw));
            exp.push_back(word_of(1'b1, rw));
            repeat (1 + ($random(seed) & 63)) @(posedge mclk_in); // Uneven word rate
        end
    endtask
    task automatic drain(input int skip);
        while (got.size() < exp.size() + skip)
            @(posedge mclk_in);
        foreach (exp[i]) check(32'(got[i+skip]), 32'(exp[i]));
        got.delete();
        exp.delete();
    endtask
    task automatic toggles(output int no, output int nb);
        logic po, pb;
        no = 0;
        nb = 0;
        repeat (64)
        begin
            po = osc;
            pb = bclk_d;
            @(posedge mclk_in);
            no += int'(osc != po);
            nb += int'(bclk_d != pb);
        end
    endtask
    // Main sequence: reset values, slave, overflow, master
    initial
    begin
        int no, nb;
        repeat (8) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        rd_chk(acu_pkg::ACU_CTRL_OFS, 32'h0);
        rd_chk(acu_pkg::ACU_OSC_INC_OFS, 32'h0);
        rd_chk(acu_pkg::ACU_DIVISOR_OFS, 32'h1);
        rd_chk(acu_pkg::ACU_STATUS_OFS, 32'h0);
        bus(1'b1, 4'h2, 32'hffff_ffff);
        rd_chk(4'h2, 32'h0);
        rd_chk(acu_pkg::ACU_CTRL_OFS, 32'h0);
        for (int e = 1; e >= 0; e--)
        begin
            rise = e[0];
            bus(1'b1, acu_pkg::ACU_CTRL_OFS, {29'h0, e[0], 2'h1});
            frames(6);
            drain(0);
            bus(1'b1, acu_pkg::ACU_CTRL_OFS, 32'h0);
        end
        rdy_on <= 1'b0;
        bus(1'b1, acu_pkg::ACU_CTRL_OFS, 32'h1);
        frames(2);
        void'(exp.pop_back());
        void'(exp.pop_back());
        rd_chk(acu_pkg::ACU_STATUS_OFS, 32'h3);
        bus(1'b1, acu_pkg::ACU_STATUS_OFS, 32'h1);
        rd_chk(acu_pkg::ACU_STATUS_OFS, 32'h2);
        rdy_on <= 1'b1;
        drain(0);
        bus(1'b1, acu_pkg::ACU_CTRL_OFS, 32'h0);
        bus(1'b1, acu_pkg::ACU_OSC_INC_OFS, 32'h2000_0000);
        bus(1'b1, acu_pkg::ACU_DIVISOR_OFS, 32'h2);
        lw = 16'h8001;
        rw = 16'h7ffe;
        for (int e = 1; e >= 0; e--)
        begin
            rise = e[0];
            bus(1'b1, acu_pkg::ACU_CTRL_OFS, {29'h0, e[0], 2'h3});
            rd_chk(acu_pkg::ACU_STATUS_OFS, 32'h4);
            check(32'({bclk_oe, ws_oe}), 32'h3);
            repeat (16) @(posedge mclk_in);
            toggles(no, nb);
            check(32'(no), 32'h10);
            check(32'(nb), 32'h8);
            repeat (2)
            begin
                exp.push_back(word_of(1'b0, lw));
                exp.push_back(word_of(1'b1, rw));
            end
            drain(2);
            bus(1'b1, acu_pkg::ACU_CTRL_OFS, 32'h0);
            repeat (20) @(posedge mclk_in);
            got.delete();
        end
        check(32'({bclk_oe, ws_oe}), 32'h0);
        report_and_stop();
    end
endmodule // tb
